// ==== logic/cstreg_cfg.svh ====
// ---------------------------------------------------------------
// core status registers: addresses, reset values, field positions
// ---------------------------------------------------------------
// assumes an 8-bit special-function address space shared with other units
`ifndef CSTREG_CFG_SVH
`define CSTREG_CFG_SVH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define CSTREG_SP_ADDR 8'h81
`define CSTREG_DPL_ADDR 8'h82
`define CSTREG_DPH_ADDR 8'h83
`define CSTREG_PSW_ADDR 8'hD0
`define CSTREG_ACC_ADDR 8'hE0
`define CSTREG_B_ADDR 8'hF0

// reserved locations, no register behind them
`define CSTREG_RSV0_ADDR 8'h97
`define CSTREG_RSV1_ADDR 8'hA2
`define CSTREG_RSV2_ADDR 8'hB3
`define CSTREG_RSV3_ADDR 8'hB4
`define CSTREG_RSV4_ADDR 8'hCE
`define CSTREG_RSV5_ADDR 8'hDF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CSTREG_SP_RST 8'h07
`define CSTREG_PSW_RST 8'h00
`define CSTREG_ACC_RST 8'h00
`define CSTREG_B_RST 8'h00
`define CSTREG_DPL_RST 8'h00
`define CSTREG_DPH_RST 8'h00

// ---------------------------------------------------------------
// status word field positions
// ---------------------------------------------------------------
`define CSTREG_CY_BIT 7
`define CSTREG_AC_BIT 6
`define CSTREG_F0_BIT 5
`define CSTREG_RSH_BIT 4
`define CSTREG_RSL_BIT 3
`define CSTREG_OV_BIT 2
`define CSTREG_F1_BIT 1
`define CSTREG_PAR_BIT 0

// each working bank spans eight bytes
`define CSTREG_BANK_SHIFT 3

`endif

// ==== logic/cstreg_pkg.sv ====
// ---------------------------------------------------------------
// core status registers: shared types
// ---------------------------------------------------------------
// assumes the constants header is included by the modules that use it
package cstreg_pkg;

    // one byte of special-function space
    typedef logic [7:0] cstreg_byte_t;

    // push sequence: bump the pointer, then write the stack byte
    typedef enum logic [1:0] {
        PS_IDLE = 2'b01,
        PS_WRITE = 2'b10
    } cstreg_push_t;

endpackage

// ==== logic/cstreg_byte_reg.sv ====
// ---------------------------------------------------------------
// one byte register with byte, bit and hardware write ports
// ---------------------------------------------------------------
// assumes all write strobes are single-cycle levels in the clk domain
`timescale 1ns/1ps
module cstreg_byte_reg import cstreg_pkg::*; #(
    parameter cstreg_byte_t RST = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // software byte and bit writes
    input wire logic swWrEn,
    input wire cstreg_byte_t swWrData,
    input wire logic bitWrEn,
    input wire logic [2:0] bitIdx,
    input wire logic bitVal,
    // execution unit write
    input wire logic hwWrEn,
    input wire cstreg_byte_t hwWrData,
    // stored value
    output cstreg_byte_t value
);

    cstreg_byte_t val_q;
    cstreg_byte_t val_d;

    // hardware result wins, it is the instruction's own outcome
    always_comb begin
        val_d = val_q;
        if (hwWrEn) begin
            val_d = hwWrData;
        end else if (swWrEn) begin
            val_d = swWrData;
        end else if (bitWrEn) begin
            val_d[bitIdx] = bitVal;
        end
    end

    // storage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            val_q <= RST;
        end else begin
            val_q <= val_d;
        end
    end

    assign value = val_q;

endmodule

// ==== logic/cstreg_core.sv ====
// ---------------------------------------------------------------
// core status registers: stack top, data pointer, status word,
// primary and second operand registers
// ---------------------------------------------------------------
// assumes one execution unit drives the hardware strobes and the same
// core drives the special-function byte and bit ports, all on clk
//
// Notes on behaviour
// - push bumps pointer, then writes byte
// - stack top resets to seven, fully writable
// - two byte registers form 16-bit pointer
// - pointer addresses external data and program
// - carry flag follows arithmetic carry/borrow
// - nibble carry follows carry into nibble
// - signed range flag follows arithmetic overflow
// - bank bits pick eight-byte register bank
// - parity bit read-only, odd ones reads one
// - user flags changed only by software
// - primary operand at E0, resets zero
// - second operand at F0, resets zero
// - undefined addresses are reserved, inert
`timescale 1ns/1ps
`include "cstreg_cfg.svh"
module cstreg_core import cstreg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // special-function byte access
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire cstreg_byte_t sfrWrData,
    input wire logic sfrRdEn,
    output cstreg_byte_t sfrRdData,
    output logic sfrRdValid,
    output logic sfrHit,
    output logic sfrReserved,
    // special-function bit access
    input wire logic sfrBitEn,
    input wire logic [7:0] sfrBitAddr,
    input wire logic sfrBitVal,
    // execution unit results
    input wire logic aluFlagEn,
    input wire logic aluCarry,
    input wire logic aluNibble,
    input wire logic aluOverflow,
    input wire logic accWrEn,
    input wire cstreg_byte_t accWrData,
    input wire logic bWrEn,
    input wire cstreg_byte_t bWrData,
    input wire logic dptrWrEn,
    input wire logic [15:0] dptrWrData,
    // stack requests and stack memory write
    input wire logic pushReq,
    input wire cstreg_byte_t pushData,
    input wire logic popReq,
    output logic pushBusy,
    output logic stackWrEn,
    output cstreg_byte_t stackWrAddr,
    output cstreg_byte_t stackWrData,
    output cstreg_byte_t stackTop,
    // views for the core
    output cstreg_byte_t accValue,
    output cstreg_byte_t bValue,
    output logic [15:0] memPtr16,
    output logic [4:0] bankBase,
    output cstreg_byte_t statusWord,
    output logic parityFlag
);

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------

    // locations with no register behind them
    function automatic logic isReserved(input logic [7:0] a);
        return (a == `CSTREG_RSV0_ADDR) || (a == `CSTREG_RSV1_ADDR) ||
            (a == `CSTREG_RSV2_ADDR) || (a == `CSTREG_RSV3_ADDR) ||
            (a == `CSTREG_RSV4_ADDR) || (a == `CSTREG_RSV5_ADDR);
    endfunction

    // bit address to owning byte address, only the upper half is bit space
    function automatic logic bitHits(input logic [7:0] ba, input logic [7:0] ra);
        return ba[7] && ({ba[7:3], 3'h0} == ra);
    endfunction

    logic wrSp;
    logic wrPsw;
    logic wrAcc;
    logic wrB;
    logic wrDpl;
    logic wrDph;
    logic bitPsw;
    logic bitAcc;
    logic bitB;

    // byte strobes per register, bit strobes for the status word and both operands only
    always_comb begin
        wrSp = sfrWrEn && (sfrAddr == `CSTREG_SP_ADDR);
        wrPsw = sfrWrEn && (sfrAddr == `CSTREG_PSW_ADDR);
        wrAcc = sfrWrEn && (sfrAddr == `CSTREG_ACC_ADDR);
        wrB = sfrWrEn && (sfrAddr == `CSTREG_B_ADDR);
        wrDpl = sfrWrEn && (sfrAddr == `CSTREG_DPL_ADDR);
        wrDph = sfrWrEn && (sfrAddr == `CSTREG_DPH_ADDR);
        bitPsw = sfrBitEn && bitHits(sfrBitAddr, `CSTREG_PSW_ADDR);
        bitAcc = sfrBitEn && bitHits(sfrBitAddr, `CSTREG_ACC_ADDR);
        bitB = sfrBitEn && bitHits(sfrBitAddr, `CSTREG_B_ADDR);
    end

    // ---------------------------------------------------------------
    // operand registers and data pointer
    // ---------------------------------------------------------------
    cstreg_byte_t dplValue;
    cstreg_byte_t dphValue;

    cstreg_byte_reg #(.RST(`CSTREG_ACC_RST)) uAcc (
        .clk(clk), .arst_n(arst_n),
        .swWrEn(wrAcc), .swWrData(sfrWrData),
        .bitWrEn(bitAcc), .bitIdx(sfrBitAddr[2:0]), .bitVal(sfrBitVal),
        .hwWrEn(accWrEn), .hwWrData(accWrData),
        .value(accValue)
    );
    cstreg_byte_reg #(.RST(`CSTREG_B_RST)) uB (
        .clk(clk), .arst_n(arst_n),
        .swWrEn(wrB), .swWrData(sfrWrData),
        .bitWrEn(bitB), .bitIdx(sfrBitAddr[2:0]), .bitVal(sfrBitVal),
        .hwWrEn(bWrEn), .hwWrData(bWrData),
        .value(bValue)
    );
    // low and high bytes, each separately addressable
    cstreg_byte_reg #(.RST(`CSTREG_DPL_RST)) uDpl (
        .clk(clk), .arst_n(arst_n),
        .swWrEn(wrDpl), .swWrData(sfrWrData),
        .bitWrEn(1'b0), .bitIdx(3'h0), .bitVal(1'b0),
        .hwWrEn(dptrWrEn), .hwWrData(dptrWrData[7:0]),
        .value(dplValue)
    );
    cstreg_byte_reg #(.RST(`CSTREG_DPH_RST)) uDph (
        .clk(clk), .arst_n(arst_n),
        .swWrEn(wrDph), .swWrData(sfrWrData),
        .bitWrEn(1'b0), .bitIdx(3'h0), .bitVal(1'b0),
        .hwWrEn(dptrWrEn), .hwWrData(dptrWrData[15:8]),
        .value(dphValue)
    );

    // one pointer feeds both external data and program fetches
    assign memPtr16 = {dphValue, dplValue};
    // odd count of ones reads as one
    // no storage, so it is current one cycle after any write
    assign parityFlag = ^accValue;

    // ---------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------
    logic [7:1] psw_q;
    logic [7:1] psw_d;

    // alu outcome beats a software write in the same cycle
    always_comb begin
        psw_d = psw_q;
        if (wrPsw) begin
            psw_d = sfrWrData[7:1];
        end else if (bitPsw && (sfrBitAddr[2:0] != 3'h0)) begin
            psw_d[sfrBitAddr[2:0]] = sfrBitVal;
        end
        if (aluFlagEn) begin
            // carry set or cleared by every arithmetic result
            psw_d[`CSTREG_CY_BIT] = aluCarry;
            psw_d[`CSTREG_AC_BIT] = aluNibble;
            psw_d[`CSTREG_OV_BIT] = aluOverflow;
        end
    end

    // user flags only move through the software paths above
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            psw_q <= 7'(`CSTREG_PSW_RST >> 1);
        end else begin
            psw_q <= psw_d;
        end
    end

    assign statusWord = {psw_q, parityFlag};
    // bank n starts at byte n times eight
    assign bankBase = {psw_q[`CSTREG_RSH_BIT:`CSTREG_RSL_BIT], 3'h0};

    // ---------------------------------------------------------------
    // stack top pointer and push sequence
    // ---------------------------------------------------------------
    cstreg_byte_t sp_q;
    cstreg_byte_t sp_d;
    cstreg_push_t pst_q;
    cstreg_push_t pst_d;
    cstreg_byte_t pdat_q;
    cstreg_byte_t pdat_d;

    // requests are ignored while a push is still writing its byte
    always_comb begin
        sp_d = sp_q;
        pst_d = pst_q;
        pdat_d = pdat_q;
        unique case (pst_q)
            PS_IDLE: begin
                if (pushReq) begin
                    // pointer moves first, write follows next cycle
                    sp_d = sp_q + 8'h01;
                    pdat_d = pushData;
                    pst_d = PS_WRITE;
                end else if (popReq) begin
                    sp_d = sp_q - 8'h01;
                end else if (wrSp) begin
                    sp_d = sfrWrData;
                end
            end
            PS_WRITE: begin
                pst_d = PS_IDLE;
            end
        endcase
    end

    // pointer comes out of reset at seven
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_q <= `CSTREG_SP_RST;
            pst_q <= PS_IDLE;
            pdat_q <= 8'h00;
        end else begin
            sp_q <= sp_d;
            pst_q <= pst_d;
            pdat_q <= pdat_d;
        end
    end

    // byte lands where the bumped pointer now points
    assign stackWrEn = (pst_q == PS_WRITE);
    assign stackWrAddr = sp_q;
    assign stackWrData = pdat_q;
    assign stackTop = sp_q;
    assign pushBusy = (pst_q == PS_WRITE);

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    cstreg_byte_t rd_q;
    cstreg_byte_t rd_d;
    logic rdv_q;
    logic rdv_d;

    // reserved and foreign addresses read zero, writes fall away
    always_comb begin
        sfrReserved = isReserved(sfrAddr);
        sfrHit = 1'b1;
        rd_d = rd_q;
        rdv_d = sfrRdEn;
        unique case (sfrAddr)
            `CSTREG_SP_ADDR: rd_d = sp_q;
            `CSTREG_DPL_ADDR: rd_d = dplValue;
            `CSTREG_DPH_ADDR: rd_d = dphValue;
            `CSTREG_PSW_ADDR: rd_d = statusWord;
            `CSTREG_ACC_ADDR: rd_d = accValue;
            `CSTREG_B_ADDR: rd_d = bValue;
            default: begin
                rd_d = 8'h00;
                sfrHit = 1'b0;
            end
        endcase
        if (!sfrRdEn) begin
            rd_d = rd_q;
        end
    end

    // data is held until the next read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 8'h00;
            rdv_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            rdv_q <= rdv_d;
        end
    end

    assign sfrRdData = rd_q;
    assign sfrRdValid = rdv_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_push_order: assert property (pushReq && !pushBusy |=>
        stackWrEn && stackWrAddr == $past(sp_q) + 8'h01 && stackWrData == $past(pushData) ##1 !stackWrEn)
        else $error("push did not bump pointer before writing");
    chk_sp_reset: assert property (disable iff (1'b0) $rose(arst_n) |-> stackTop == 8'h07)
        else $error("stack pointer not seven after reset");
    chk_ptr_load: assert property (dptrWrEn |=> memPtr16 == $past(dptrWrData))
        else $error("data pointer did not take the execution unit value");
    chk_carry_track: assert property (aluFlagEn |=> statusWord[7] == $past(aluCarry))
        else $error("carry flag does not follow arithmetic result");
    chk_nibble_track: assert property (aluFlagEn |=> statusWord[6] == $past(aluNibble))
        else $error("nibble carry does not follow arithmetic result");
    chk_range_track: assert property (aluFlagEn |=> statusWord[2] == $past(aluOverflow))
        else $error("signed range flag does not follow arithmetic result");
    chk_bank_map: assert property (wrPsw |=> bankBase == {$past(sfrWrData[4:3]), 3'h0})
        else $error("bank base does not match written select bits");
    // parity current in the cycle after an operand load
    chk_parity_acc: assert property (accWrEn |=>
        parityFlag == ^$past(accWrData) && statusWord[0] == parityFlag)
        else $error("parity bit wrong after operand write");
    chk_user_hold: assert property (!wrPsw && !bitPsw |=> $stable(statusWord[5]) && $stable(statusWord[1]))
        else $error("user flag changed without software write");
    chk_second_load: assert property (bWrEn |=> bValue == $past(bWrData))
        else $error("second operand did not take its value");
    chk_reserved_read: assert property (sfrRdEn && sfrReserved |=> sfrRdValid && sfrRdData == 8'h00)
        else $error("reserved address returned data");

    cov_push: cover property (pushReq && !pushBusy ##1 stackWrEn);
    cov_alu_flags: cover property (aluFlagEn && aluCarry && aluOverflow);
    cov_bank3: cover property (bankBase == 5'h18);
    cov_reserved: cover property (sfrRdEn && sfrReserved);

endmodule

// ==== verif/cstreg_core_tb.sv ====
// ---------------------------------------------------------------
// self-checking bench for the core status registers
// ---------------------------------------------------------------
// assumes the bench drives every port itself, inputs on the falling edge
`timescale 1ns/1ps
`include "cstreg_cfg.svh"
module cstreg_core_tb import cstreg_pkg::*;;

    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic clk, arst_n;
    logic [7:0] sfrAddr, sfrBitAddr;
    logic sfrWrEn, sfrRdEn, sfrBitEn, sfrBitVal, sfrRdValid, sfrHit, sfrReserved;
    cstreg_byte_t sfrWrData, sfrRdData, accWrData, bWrData, pushData;
    logic aluFlagEn, aluCarry, aluNibble, aluOverflow, accWrEn, bWrEn, dptrWrEn;
    logic [15:0] dptrWrData, memPtr16;
    logic pushReq, popReq, pushBusy, stackWrEn, parityFlag;
    cstreg_byte_t stackWrAddr, stackWrData, stackTop, accValue, bValue, statusWord;
    logic [4:0] bankBase;
    int errTotal = 0;
    int comparisons = 0;

    cstreg_core dut_u (
        .clk(clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .sfrRdValid(sfrRdValid), .sfrHit(sfrHit), .sfrReserved(sfrReserved),
        .sfrBitEn(sfrBitEn), .sfrBitAddr(sfrBitAddr), .sfrBitVal(sfrBitVal),
        .aluFlagEn(aluFlagEn), .aluCarry(aluCarry), .aluNibble(aluNibble),
        .aluOverflow(aluOverflow), .accWrEn(accWrEn), .accWrData(accWrData),
        .bWrEn(bWrEn), .bWrData(bWrData), .dptrWrEn(dptrWrEn), .dptrWrData(dptrWrData),
        .pushReq(pushReq), .pushData(pushData), .popReq(popReq), .pushBusy(pushBusy),
        .stackWrEn(stackWrEn), .stackWrAddr(stackWrAddr), .stackWrData(stackWrData),
        .stackTop(stackTop), .accValue(accValue), .bValue(bValue), .memPtr16(memPtr16),
        .bankBase(bankBase), .statusWord(statusWord), .parityFlag(parityFlag)
    );

    // free-running 250 MHz clock
    always #2 clk = ~clk;

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // byte write: one-cycle strobe, new value visible at the next falling edge
    task automatic wr(input logic [7:0] a, input cstreg_byte_t d);
        @(negedge clk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge clk);
        sfrWrEn = 1'b0;
    endtask

    // byte read: answer lands one cycle after the strobe edge
    task automatic rdchk(input logic [7:0] a, input cstreg_byte_t exp, input string what);
        @(negedge clk);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge clk);
        sfrRdEn = 1'b0;
        chk({15'h0000, sfrRdValid}, 16'h0001, "read valid");
        chk({8'h00, sfrRdData}, {8'h00, exp}, what);
    endtask

    task automatic bitwr(input logic [7:0] ba, input logic v);
        @(negedge clk);
        sfrBitAddr = ba;
        sfrBitVal = v;
        sfrBitEn = 1'b1;
        @(negedge clk);
        sfrBitEn = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk({8'h00, stackTop}, 16'h0007, "stack top reset");
        rdchk(`CSTREG_SP_ADDR, 8'h07, "stack top read");
        rdchk(`CSTREG_PSW_ADDR, 8'h00, "status read");
        rdchk(`CSTREG_ACC_ADDR, 8'h00, "operand read");
        rdchk(`CSTREG_B_ADDR, 8'h00, "second operand read");
    endtask

    // push held over the busy cycle: the second request must be dropped
    task automatic t_stack();
        wr(`CSTREG_SP_ADDR, 8'hFF);
        rdchk(`CSTREG_SP_ADDR, 8'hFF, "stack top all bits");
        wr(`CSTREG_SP_ADDR, 8'h07);
        // a pop in the same cycle must lose to the push
        @(negedge clk);
        pushReq = 1'b1;
        popReq = 1'b1;
        pushData = 8'hAA;
        @(negedge clk);
        pushData = 8'h55;
        chk({8'h00, stackTop}, 16'h0008, "pointer bumped");
        chk({7'h00, stackWrEn, stackWrAddr}, 16'h0108, "write at new top");
        chk({7'h00, pushBusy, stackWrData}, 16'h01AA, "pushed byte");
        @(negedge clk);
        pushReq = 1'b0;
        chk({7'h00, stackWrEn, stackTop}, 16'h0008, "busy push and pop dropped");
        popReq = 1'b1;
        @(negedge clk);
        popReq = 1'b0;
        chk({8'h00, stackTop}, 16'h0007, "pop decrements");
    endtask

    task automatic t_pointer();
        wr(`CSTREG_DPL_ADDR, 8'h34);
        wr(`CSTREG_DPH_ADDR, 8'h12);
        chk(memPtr16, 16'h1234, "pointer from bytes");
        @(negedge clk);
        dptrWrEn = 1'b1;
        dptrWrData = 16'hABCD;
        @(negedge clk);
        dptrWrEn = 1'b0;
        chk(memPtr16, 16'hABCD, "pointer load");
        rdchk(`CSTREG_DPL_ADDR, 8'hCD, "low byte");
        rdchk(`CSTREG_DPH_ADDR, 8'hAB, "high byte");
    endtask

    // every flag combination, user flags parked at one throughout
    task automatic t_flags();
        bitwr(8'hD5, 1'b1);
        bitwr(8'hD1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            aluFlagEn = 1'b1;
            {aluCarry, aluNibble, aluOverflow} = i[2:0];
            @(negedge clk);
            aluFlagEn = 1'b0;
            chk({15'h0000, statusWord[7]}, {15'h0000, i[2]}, "carry");
            chk({15'h0000, statusWord[6]}, {15'h0000, i[1]}, "nibble carry");
            chk({15'h0000, statusWord[2]}, {15'h0000, i[0]}, "signed range");
            chk({14'h0000, statusWord[5], statusWord[1]}, 16'h0003, "user flags");
        end
        wr(`CSTREG_PSW_ADDR, 8'h00);
        chk({14'h0000, statusWord[5], statusWord[1]}, 16'h0000, "user flags clear");
    endtask

    task automatic t_bank();
        for (int i = 0; i < 4; i++) begin
            wr(`CSTREG_PSW_ADDR, {3'b000, i[1:0], 3'b000});
            chk({11'h000, bankBase}, {11'h000, i[1:0], 3'b000}, "bank base");
        end
        wr(`CSTREG_PSW_ADDR, 8'h00);
    endtask

    // parity must follow the operand the cycle after each load
    task automatic t_parity();
        cstreg_byte_t vals [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFE, 8'hFF};
        foreach (vals[k]) begin
            @(negedge clk);
            accWrEn = 1'b1;
            accWrData = vals[k];
            @(negedge clk);
            accWrEn = 1'b0;
            chk({15'h0000, parityFlag}, {15'h0000, ^vals[k]}, "parity");
            chk({15'h0000, statusWord[0]}, {15'h0000, ^vals[k]}, "status parity");
        end
        wr(`CSTREG_PSW_ADDR, 8'h01);
        rdchk(`CSTREG_PSW_ADDR, 8'h00, "parity not writable");
    endtask

    task automatic t_bits();
        wr(`CSTREG_ACC_ADDR, 8'h00);
        bitwr(8'hE3, 1'b1);
        bitwr(8'hE4, 1'b1);
        chk({8'h00, accValue}, 16'h0018, "operand bit write");
        bitwr(8'hF7, 1'b1);
        chk({8'h00, bValue}, 16'h0080, "second bit write");
        wr(`CSTREG_B_ADDR, 8'h5A);
        rdchk(`CSTREG_B_ADDR, 8'h5A, "second byte");
        rdchk(`CSTREG_ACC_ADDR, 8'h18, "operand byte");
        bitwr(8'hD0, 1'b1);
        chk({15'h0000, statusWord[0]}, 16'h0000, "parity bit refused");
    endtask

    task automatic t_reserved();
        logic [7:0] rsv [6] = '{8'h97, 8'hA2, 8'hB3, 8'hB4, 8'hCE, 8'hDF};
        foreach (rsv[k]) begin
            wr(rsv[k], 8'hFF);
            chk({14'h0000, sfrReserved, sfrHit}, 16'h0002, "reserved decode");
            rdchk(rsv[k], 8'h00, "reserved reads zero");
        end
        // leave the reserved location at zero, as software is expected to
        wr(`CSTREG_RSV0_ADDR, 8'h00);
        rdchk(`CSTREG_B_ADDR, 8'h5A, "no side effect");
        // a defined address must decode as a hit, and valid lasts one cycle
        @(negedge clk);
        chk({13'h0000, sfrReserved, sfrHit, sfrRdValid}, 16'h0002, "hit decode");
    endtask

    // ---------------------------------------------------------------
    // closing, watchdog and main sequence
    // ---------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // the whole run needs about 133 cycles; this allows ample margin
    initial begin
        repeat (5000) @(posedge clk);
        errTotal++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {sfrAddr, sfrBitAddr, sfrWrData, accWrData, bWrData, pushData} = '0;
        {sfrWrEn, sfrRdEn, sfrBitEn, sfrBitVal, accWrEn, bWrEn, dptrWrEn} = '0;
        {aluFlagEn, aluCarry, aluNibble, aluOverflow, pushReq, popReq} = '0;
        dptrWrData = 16'h0000;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_stack();
        t_pointer();
        t_flags();
        t_bank();
        t_parity();
        t_bits();
        t_reserved();
        stop_test();
    end

endmodule
